/* logic/csl_pkg.sv */
// Package of constants and types for the configuration and security loader
package csl_pkg;

  // ****************************************
  // Table-read addresses of the option bytes
  // ****************************************
  localparam int          CSL_ADDR_W       = 16;
  localparam logic [15:0] CSL_OPT_ADDR     = 16'hFFF0;  // Default, overridable by parameter
  localparam logic [15:0] CSL_LOCK_ADDR    = 16'hFFF1;

  // ****************************************
  // Field positions, first byte
  // ****************************************
  localparam int CSL_RST_PIN_DIS_BIT = 6;
  localparam int CSL_PORT_LVL_BIT    = 5;
  localparam int CSL_BO_SEL_BIT      = 4;
  localparam int CSL_OSC_HI_BIT      = 1;
  localparam int CSL_OSC_LO_BIT      = 0;

  // ****************************************
  // Field positions, second byte
  // ****************************************
  localparam int CSL_PROG_LOCK_BIT = 7;
  localparam int CSL_DATA_LOCK_BIT = 6;

  // ****************************************
  // Values after reset and blank flash
  // ****************************************
  localparam logic [7:0] CSL_BLANK_BYTE = 8'hFF;
  localparam logic [7:0] CSL_ZERO_BYTE  = 8'h00;
  localparam logic [1:0] CSL_ZERO_IDX   = 2'h0;
  localparam logic [1:0] CSL_LAST_IDX   = 2'h1;

  // Oscillator source encodings
  typedef enum logic [1:0] {
    CSL_OSC_XTAL = 2'h0,
    CSL_OSC_RC   = 2'h1,
    CSL_OSC_RSVD = 2'h2,
    CSL_OSC_EXT  = 2'h3
  } csl_osc_t;

  // Area selector for external access
  typedef enum logic [1:0] {
    CSL_AREA_PROG = 2'h0,
    CSL_AREA_DATA = 2'h1,
    CSL_AREA_CFG  = 2'h2,
    CSL_AREA_NONE = 2'h3
  } csl_area_t;

endpackage

/* logic/csl_sync.sv */
// Two-flop synchroniser bank for pin-side inputs
`timescale 1ns/1ps
module csl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  initial begin
    if (WIDTH < 1) begin
      $error("csl_sync: WIDTH must be at least 1");
    end
  end

  // Next values, first flop read only by the second
  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  // Register stage
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule

/* logic/csl_loader.sv */
// Power-up option loader, code protection and in-circuit programming pin control
// Notes on behaviour
// - On entry to in-circuit programming every pin goes quasi-bidirectional with its latch at one.
// - Settings are taken from the stored bytes at power-up and cannot change once code runs.
// - Code reads both option bytes through a table read at their assigned addresses.
// - Bit 6 of the first byte at one removes the reset role of the reset-capable pin.
// - Bit 5 of the first byte sets the port level during reset, zero low and one high.
// - Bit 4 of the first byte picks the brownout level, zero 3.8V and one 2.5V.
// - Bits 1 and 0 pick crystal, internal RC, reserved or external clock as 00, 01, 10, 11.
// - Program lock at zero refuses outside reads of program flash and any access to the option bytes.
// - Data lock at zero refuses outside reads of data flash and any access to the option bytes.
// - With both locks at one the programmer may erase, program and read both areas.
// - 0/1 blocks program readout only, 0/0 blocks both, and 1/0 is flagged invalid.
// - The programmer may work on program flash and data area separately or together.
// - Flash is delivered blank, so blank bytes give the unlocked, default settings.
`timescale 1ns/1ps
module csl_loader
  import csl_pkg::*;
#(
  parameter logic [CSL_ADDR_W-1:0] OPT_ADDR  = CSL_OPT_ADDR,
  parameter logic [CSL_ADDR_W-1:0] LOCK_ADDR = CSL_LOCK_ADDR,
  parameter int                    NPINS     = 16
) (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_nrst,
  // Stored bytes from the flash array
  input  wire logic [7:0]            i_nv_option_byte,
  input  wire logic [7:0]            i_nv_lock_byte,
  // Loader holds core in reset until done
  output logic                       o_load_done,
  // Table-read port from the CPU
  input  wire logic                  i_tbl_rd,
  input  wire logic [CSL_ADDR_W-1:0] i_tbl_addr,
  output logic                       o_tbl_hit,
  output logic [7:0]                 o_tbl_data,
  // Programming entry pin, asynchronous
  input  wire logic                  i_prog_entry,
  // External access request from programmer
  input  wire logic                  i_ext_req,
  input  wire csl_area_t             i_ext_area,
  input  wire logic                  i_ext_read,
  output logic                       o_ext_grant,
  output logic                       o_ext_refused,
  // Decoded controls
  output logic                       o_reset_pin_disable,
  output logic                       o_port_reset_level,
  output logic                       o_brownout_threshold_select,
  output logic                       o_osc_select_hi,
  output logic                       o_osc_select_lo,
  output logic                       o_osc_reserved,
  output logic                       o_lock_invalid,
  // Pin mode override
  output logic                       o_in_circuit_programming,
  output logic                       o_pins_quasi_bidir,
  output logic [NPINS-1:0]           o_pin_latch_force,
  output logic [NPINS-1:0]           o_pin_latch_value
);

  initial begin
    if (NPINS < 1) begin
      $error("csl_loader: NPINS must be at least 1");
    end
    if (OPT_ADDR == LOCK_ADDR) begin
      $error("csl_loader: byte addresses must differ");
    end
  end

  // ****************************************
  // Power-up capture
  // ****************************************

  logic [7:0] power_up_option_byte;
  logic [7:0] security_lock_byte;
  logic [1:0] load_idx;
  logic       loaded;
  logic [7:0] next_option;
  logic [7:0] next_lock;
  logic [1:0] next_idx;
  logic       next_loaded;

  // Capture after release; an asynchronous copy of the port would be unsafe
  always_comb begin
    next_option = power_up_option_byte;
    next_lock   = security_lock_byte;
    next_idx    = load_idx;
    next_loaded = loaded;
    if (!loaded) begin
      if (load_idx == CSL_ZERO_IDX) begin
        next_option = i_nv_option_byte;
        next_idx    = CSL_LAST_IDX;
      end else begin
        next_lock   = i_nv_lock_byte;
        next_loaded = 1'b1;
      end
    end
  end

  // Blank-state defaults until the latches are filled
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      power_up_option_byte <= CSL_BLANK_BYTE;
      security_lock_byte   <= CSL_BLANK_BYTE;
      load_idx             <= CSL_ZERO_IDX;
      loaded               <= 1'b0;
    end else begin
      power_up_option_byte <= next_option;
      security_lock_byte   <= next_lock;
      load_idx             <= next_idx;
      loaded               <= next_loaded;
    end
  end

  // ****************************************
  // Decoded controls, only from the latches
  // ****************************************

  logic prog_lock;
  logic data_lock;

  always_comb begin
    o_reset_pin_disable         = power_up_option_byte[CSL_RST_PIN_DIS_BIT];
    o_port_reset_level          = power_up_option_byte[CSL_PORT_LVL_BIT];
    o_brownout_threshold_select = power_up_option_byte[CSL_BO_SEL_BIT];
    o_osc_select_hi             = power_up_option_byte[CSL_OSC_HI_BIT];
    o_osc_select_lo             = power_up_option_byte[CSL_OSC_LO_BIT];
    o_osc_reserved              = ({o_osc_select_hi, o_osc_select_lo}
                                   == CSL_OSC_RSVD);
    o_load_done                 = loaded;
    // Locks are active low in the stored byte
    prog_lock      = ~security_lock_byte[CSL_PROG_LOCK_BIT];
    data_lock      = ~security_lock_byte[CSL_DATA_LOCK_BIT];
    o_lock_invalid = ~prog_lock & data_lock;
  end

  // ****************************************
  // Table read by running code
  // ****************************************

  logic       next_hit;
  logic [7:0] next_tbl_data;

  // Reserved bits come back exactly as stored
  always_comb begin
    next_hit      = 1'b0;
    next_tbl_data = CSL_ZERO_BYTE;
    if (i_tbl_rd && i_tbl_addr == OPT_ADDR) begin
      next_hit      = 1'b1;
      next_tbl_data = power_up_option_byte;
    end else if (i_tbl_rd && i_tbl_addr == LOCK_ADDR) begin
      next_hit      = 1'b1;
      next_tbl_data = security_lock_byte;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_tbl_hit  <= 1'b0;
      o_tbl_data <= CSL_ZERO_BYTE;
    end else begin
      o_tbl_hit  <= next_hit;
      o_tbl_data <= next_tbl_data;
    end
  end

  // ****************************************
  // Programming entry and external access
  // ****************************************

  logic entry_sync;
  logic next_grant;
  logic next_refused;
  logic next_prog_mode;

  csl_sync #(
    .WIDTH (1)
  ) u_entry_sync (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_prog_entry),
    .o_sync     (entry_sync)
  );

  // Protection decision; both areas can be served in one session
  always_comb begin
    next_prog_mode = entry_sync & loaded;
    next_grant   = 1'b0;
    next_refused = 1'b0;
    if (i_ext_req && o_in_circuit_programming) begin
      if (i_ext_area == CSL_AREA_CFG && (prog_lock || data_lock)) begin
        next_refused = 1'b1;
      end else if (i_ext_area == CSL_AREA_PROG && prog_lock && i_ext_read) begin
        next_refused = 1'b1;
      end else if (i_ext_area == CSL_AREA_DATA && data_lock && i_ext_read) begin
        next_refused = 1'b1;
      end else if (i_ext_area == CSL_AREA_NONE) begin
        next_refused = 1'b1;
      end else begin
        next_grant   = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_in_circuit_programming <= 1'b0;
      o_ext_grant              <= 1'b0;
      o_ext_refused            <= 1'b0;
    end else begin
      o_in_circuit_programming <= next_prog_mode;
      o_ext_grant              <= next_grant;
      o_ext_refused            <= next_refused;
    end
  end

  // Pins quasi-bidirectional, latches high while programming
  always_comb begin
    o_pins_quasi_bidir = o_in_circuit_programming;
    o_pin_latch_force  = {NPINS{o_in_circuit_programming}};
    o_pin_latch_value  = {NPINS{1'b1}};
  end

endmodule

/* dv/csl_loader_props.sv */
// Port checker for the option loader
`timescale 1ns/1ps
module csl_loader_props
  import csl_pkg::*;
#(
  parameter logic [CSL_ADDR_W-1:0] OPT_ADDR  = CSL_OPT_ADDR,
  parameter logic [CSL_ADDR_W-1:0] LOCK_ADDR = CSL_LOCK_ADDR,
  parameter int                    NPINS     = 16
) (
  // Clock and reset
  input wire logic                  i_core_clk,
  input wire logic                  i_nrst,
  // Requests
  input wire logic                  i_tbl_rd,
  input wire logic [CSL_ADDR_W-1:0] i_tbl_addr,
  input wire logic                  i_ext_req,
  input wire csl_area_t             i_ext_area,
  // Answers and controls
  input wire logic                  o_load_done,
  input wire logic                  o_tbl_hit,
  input wire logic [7:0]            o_tbl_data,
  input wire logic                  o_ext_grant,
  input wire logic                  o_ext_refused,
  input wire logic                  o_reset_pin_disable,
  input wire logic                  o_port_reset_level,
  input wire logic                  o_brownout_threshold_select,
  input wire logic                  o_osc_select_hi,
  input wire logic                  o_osc_select_lo,
  input wire logic                  o_osc_reserved,
  input wire logic                  o_lock_invalid,
  input wire logic                  o_in_circuit_programming,
  input wire logic [NPINS-1:0]      o_pin_latch_force,
  input wire logic [NPINS-1:0]      o_pin_latch_value
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire logic [4:0] ctl = {o_reset_pin_disable, o_port_reset_level,
    o_brownout_threshold_select, o_osc_select_hi, o_osc_select_lo};
  wire logic pmode = o_in_circuit_programming;
  property p_tbl_opt;
    i_tbl_rd && i_tbl_addr == OPT_ADDR && o_load_done
      |=> o_tbl_hit && {o_tbl_data[6:4], o_tbl_data[1:0]} == ctl;
  endproperty
  a_tbl_opt: assert property (p_tbl_opt) else $error("option read wrong");
  property p_tbl_miss;
    i_tbl_rd && i_tbl_addr != OPT_ADDR && i_tbl_addr != LOCK_ADDR |=> !o_tbl_hit && o_tbl_data == 8'h00;
  endproperty
  a_tbl_miss: assert property (p_tbl_miss) else $error("unmapped read hit");
  property p_tbl_lock;
    i_tbl_rd && i_tbl_addr == LOCK_ADDR && o_load_done
      |=> o_tbl_hit && ((o_tbl_data[7:6] == 2'h2) == o_lock_invalid);
  endproperty
  a_tbl_lock: assert property (p_tbl_lock) else $error("lock read wrong");
  property p_osc_rsvd;
    o_osc_reserved == (o_osc_select_hi && !o_osc_select_lo);
  endproperty
  a_osc_rsvd: assert property (p_osc_rsvd) else $error("reserved clock flag");
  property p_stable;
    o_load_done && $past(o_load_done) |-> $stable(ctl) && $stable(o_lock_invalid);
  endproperty
  a_stable: assert property (p_stable) else $error("setting changed");
  property p_pmode_pins;
    pmode |-> &o_pin_latch_force && &o_pin_latch_value;
  endproperty
  a_pmode_pins: assert property (p_pmode_pins) else $error("pins not forced");
  property p_ext_one;
    i_ext_req && pmode |=> o_ext_grant != o_ext_refused;
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("no single answer");
  property p_ext_none;
    i_ext_req && pmode && i_ext_area == CSL_AREA_NONE |=> o_ext_refused;
  endproperty
  a_ext_none: assert property (p_ext_none) else $error("empty area granted");
  property p_no_pmode;
    i_ext_req && !pmode |=> !o_ext_grant && !o_ext_refused;
  endproperty
  a_no_pmode: assert property (p_no_pmode) else $error("answer outside mode");
endmodule

/* dv/csl_prog_model.sv */
// Behavioural programming tool driving the access port
`timescale 1ns/1ps
module csl_prog_model
  import csl_pkg::*;
(
  // Clock
  input  wire logic      i_core_clk,
  // Command from the bench
  input  wire logic      i_go,
  input  wire csl_area_t i_area,
  input  wire logic      i_read,
  // Request to the loader
  output csl_area_t      o_ext_area,
  output logic           o_ext_req,
  output logic           o_ext_read
);
  // Idle qualifiers toggle, so a stale value is never trusted
  initial begin
    o_ext_req  = 1'b0;
    o_ext_area = CSL_AREA_NONE;
    o_ext_read = 1'b0;
  end
  // One pulse per access, back to back allowed
  always @(negedge i_core_clk) begin
    o_ext_req  <= i_go;
    o_ext_area <= i_go ? i_area : csl_area_t'(~o_ext_area);
    o_ext_read <= i_go ? i_read : ~o_ext_read;
  end
endmodule

/* dv/tb.sv */
// Self-checking bench for the option loader
`timescale 1ns/1ps
module tb;
  import csl_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        i_core_clk = 1'b0;
  logic        i_nrst     = 1'b0;
  logic [7:0]  opt = 8'hFF, lck = 8'hFF, data;
  logic        rd = 1'b0, entry = 1'b0, go = 1'b0, xrd = 1'b0;
  logic [15:0] addr = 16'h0000, frc, val;
  csl_area_t   xarea = CSL_AREA_NONE, marea;
  logic        req, mrd, done, hit, gnt, rfs, rdis, prl, bo, hi, lo, ors, inv, pmode, qb;
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  logic [7:0]  ot [5] = '{8'hFF, 8'hA5, 8'h5E, 8'h13, 8'h00};
  logic [7:0]  lt [5] = '{8'hFF, 8'h7F, 8'h3F, 8'hBF, 8'hFF};
  always #10 i_core_clk = ~i_core_clk;
  csl_prog_model csl_prog_model_inst (.i_core_clk(i_core_clk), .i_go(go), .i_area(xarea),
    .i_read(xrd), .o_ext_req(req), .o_ext_area(marea), .o_ext_read(mrd));
  csl_loader csl_loader_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_nv_option_byte(opt), .i_nv_lock_byte(lck), .o_load_done(done), .i_tbl_rd(rd),
    .i_tbl_addr(addr), .o_tbl_hit(hit), .o_tbl_data(data), .i_prog_entry(entry),
    .i_ext_req(req), .i_ext_area(marea), .i_ext_read(mrd), .o_ext_grant(gnt),
    .o_ext_refused(rfs), .o_reset_pin_disable(rdis), .o_port_reset_level(prl),
    .o_brownout_threshold_select(bo), .o_osc_select_hi(hi), .o_osc_select_lo(lo),
    .o_osc_reserved(ors), .o_lock_invalid(inv), .o_in_circuit_programming(pmode),
    .o_pins_quasi_bidir(qb), .o_pin_latch_force(frc), .o_pin_latch_value(val));
  // ****************************************
  // Shared tasks
  // ****************************************
  task stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Reset with chosen stored bytes, blank view while held
  task do_reset(input logic [7:0] o, input logic [7:0] l);
    @(negedge i_core_clk);
    i_nrst <= 1'b0;
    opt    <= o;
    lck    <= l;
    repeat (6) @(negedge i_core_clk);
    check({rdis, prl, bo, hi, lo}, 16'h001F);
    i_nrst <= 1'b1;
    repeat (3) @(negedge i_core_clk);
    check(done, 1'b1);
  endtask
  // Table read; strobe left high so reads run back to back
  task tbl(input logic [15:0] a, input logic [7:0] e, input logic h);
    rd   <= 1'b1;
    addr <= a;
    @(negedge i_core_clk);
    check(hit, h);
    check(data, e);
  endtask
  // One access through the tool, expected answer from the lock byte
  task acc(input csl_area_t a, input logic r, input logic [7:0] l, input logic on);
    logic x;
    x = (a == CSL_AREA_CFG && l[7:6] != 2'h3) || (a == CSL_AREA_PROG && r && !l[7])
      || (a == CSL_AREA_DATA && r && !l[6]) || a == CSL_AREA_NONE;
    go    <= 1'b1;
    xarea <= a;
    xrd   <= r;
    @(negedge i_core_clk);
    go <= 1'b0;
    @(negedge i_core_clk);
    check({gnt, rfs}, on ? {!x, x} : 2'h0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_cfg(input logic [7:0] o, input logic [7:0] l);
    do_reset(o, l);
    check({rdis, prl, bo, hi, lo}, {o[6:4], o[1:0]});
    check(ors, o[1:0] == 2'h2);
    check(inv, l[7:6] == 2'h2);
    tbl(CSL_OPT_ADDR, o, 1'b1);
    tbl(CSL_LOCK_ADDR, l, 1'b1);
    tbl(16'h1234, 8'h00, 1'b0);
    rd  <= 1'b0;
    opt <= ~o;
    lck <= ~l;
    repeat (3) @(negedge i_core_clk);
    check({rdis, prl, bo, hi, lo}, {o[6:4], o[1:0]});
    tbl(CSL_OPT_ADDR, o, 1'b1);
    rd <= 1'b0;
  endtask
  task t_icp(input logic [7:0] l);
    do_reset(8'hFF, l);
    acc(CSL_AREA_PROG, 1'b1, l, 1'b0);
    entry <= 1'b1;
    for (int k = 0; k < 20 && pmode !== 1'b1; k++) @(negedge i_core_clk);
    check({pmode, qb}, 2'h3);
    check(frc & val, 16'hFFFF);
    for (int a = 0; a < 4; a++)
      for (int r = 0; r < 2; r++) acc(csl_area_t'(a), r[0], l, 1'b1);
    // Erase then option-byte write, one idle cycle apart in one session
    acc(CSL_AREA_PROG, 1'b0, l, 1'b1);
    acc(CSL_AREA_CFG, 1'b0, l, 1'b1);
    entry <= 1'b0;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    for (int i = 0; i < 5; i++) t_cfg(ot[i], lt[i]);
    for (int i = 0; i < 4; i++) t_icp(lt[i]);
    stop_test();
  end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t watchdog ran out", $time);
      stop_test();
    end
  end
endmodule
bind csl_loader csl_loader_props #(.OPT_ADDR(OPT_ADDR), .LOCK_ADDR(LOCK_ADDR), .NPINS(NPINS))
  csl_loader_props_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_tbl_rd(i_tbl_rd),
  .i_tbl_addr(i_tbl_addr), .i_ext_req(i_ext_req), .i_ext_area(i_ext_area),
  .o_load_done(o_load_done), .o_tbl_hit(o_tbl_hit), .o_tbl_data(o_tbl_data),
  .o_ext_grant(o_ext_grant), .o_ext_refused(o_ext_refused),
  .o_reset_pin_disable(o_reset_pin_disable), .o_port_reset_level(o_port_reset_level),
  .o_brownout_threshold_select(o_brownout_threshold_select),
  .o_osc_select_hi(o_osc_select_hi), .o_osc_select_lo(o_osc_select_lo),
  .o_osc_reserved(o_osc_reserved), .o_lock_invalid(o_lock_invalid),
  .o_in_circuit_programming(o_in_circuit_programming),
  .o_pin_latch_force(o_pin_latch_force), .o_pin_latch_value(o_pin_latch_value));
